// >>> rtl/pfb_cfg.svh
// Purpose: constants for the parallel flash bus host controller
// Assumes: 100 MHz MCLK, byte-wide flash with 21 address lines
// Notes:   times in ns; cycle counts are derived in the top module
`ifndef PFB_CFG_SVH
`define PFB_CFG_SVH

// bus widths
`define PFB_ADDR_W        21
`define PFB_DATA_W        8
`define PFB_TMR_W         16

// clock period
`define PFB_CLK_NS        10

// default pin timing, plain values meant to be overridden
`define PFB_ACC_NS        90
`define PFB_WP_NS         50
`define PFB_INIT_PULSE_NS 500
`define PFB_REC_EMB_NS    20000
`define PFB_REC_NEMB_NS   500
`define PFB_RH_NS         50

// user command codes
`define PFB_OP_READ       2'h0
`define PFB_OP_WRITE      2'h1
`define PFB_OP_INIT       2'h2

`endif

// >>> rtl/pfb_pkg.sv
// Purpose: types shared by the parallel flash bus host controller
// Assumes: pfb_cfg.svh holds the numbers
// Notes:   cycle helper rounds up and never returns less than one
`include "pfb_cfg.svh"

package pfb_pkg;

    typedef logic [`PFB_TMR_W-1:0] pfb_cnt_t;

    typedef enum logic [3:0] {
        PFB_PWRUP,
        PFB_IDLE,
        PFB_RD,
        PFB_WR,
        PFB_WR_HOLD,
        PFB_INIT_LOW,
        PFB_INIT_REC,
        PFB_INIT_RH
    } pfb_state_t;

    // ns to whole clock cycles, rounded up, at least one
    function automatic int unsigned pfb_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + `PFB_CLK_NS - 1) / `PFB_CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

endpackage

// >>> rtl/pfb_tmr_if.sv
// Purpose: load/done link between the sequencer and its interval timer
// Assumes: one clock domain
// Notes:   value is the number of cycles minus one
`timescale 1ns/1ps

interface pfb_tmr_if;
    logic              load;
    pfb_pkg::pfb_cnt_t value;
    logic              done;

    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface

// >>> rtl/pfb_timer.sv
// Purpose: down counter timing each pin phase
// Assumes: load pulses on the edge that enters a timed phase
// Notes:   after load of n, done rises n cycles later
`timescale 1ns/1ps

module pfb_timer (
    input  wire logic MCLK,
    input  wire logic RST,
    pfb_tmr_if.tmr    t
);

    pfb_pkg::pfb_cnt_t cnt_r;
    pfb_pkg::pfb_cnt_t cnt_nxt;

    // reload or count down to zero and stay
    always_comb begin
        if (t.load) begin
            cnt_nxt = t.value;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - `PFB_TMR_W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // counter register
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign t.done = (cnt_r == '0);

endmodule

// >>> rtl/pfb_host.sv
// Purpose: host side sequencer driving a byte-wide parallel flash
// Assumes: OP_DONE_FLAG and DATA_BUS_I synchronous to MCLK
// Notes:   one request at a time; REQ taken only while READY_OUT
// Functional notes
// - read with select and gate low, strobe high
// - write with strobe and select low, gate high
// - flag aborted operations so they get reissued
// - wait release-to-read before the next read
`timescale 1ns/1ps
`include "pfb_cfg.svh"

module pfb_host #(
    parameter int unsigned P_ACC_NS        = `PFB_ACC_NS,
    parameter int unsigned P_WP_NS         = `PFB_WP_NS,
    parameter int unsigned P_INIT_PULSE_NS = `PFB_INIT_PULSE_NS,
    parameter int unsigned P_REC_EMB_NS    = `PFB_REC_EMB_NS,
    parameter int unsigned P_REC_NEMB_NS   = `PFB_REC_NEMB_NS,
    parameter int unsigned P_RH_NS         = `PFB_RH_NS
) (
    input  wire logic                   MCLK,
    input  wire logic                   RST,
    input  wire logic                   REQ,
    input  wire logic [1:0]             OP,
    input  wire logic [`PFB_ADDR_W-1:0] ADDR_IN,
    input  wire logic [`PFB_DATA_W-1:0] WDATA,
    output logic                        READY_OUT,
    output logic                        DONE,
    output logic [`PFB_DATA_W-1:0]      RDATA,
    output logic                        ABORTED,
    output logic                        CE_N,
    output logic                        OE_N,
    output logic                        WE_N,
    output logic                        INIT_N,
    output logic [`PFB_ADDR_W-1:0]      ADDR_BUS,
    input  wire logic [`PFB_DATA_W-1:0] DATA_BUS_I,
    output logic [`PFB_DATA_W-1:0]      DATA_BUS_O,
    output logic                        DATA_BUS_OE,
    input  wire logic                   OP_DONE_FLAG
);

    localparam int unsigned ACC_CYC  = pfb_pkg::pfb_cycles(P_ACC_NS);
    localparam int unsigned WP_CYC   = pfb_pkg::pfb_cycles(P_WP_NS);
    localparam int unsigned IP_CYC   = pfb_pkg::pfb_cycles(P_INIT_PULSE_NS);
    localparam int unsigned EMB_CYC  = pfb_pkg::pfb_cycles(P_REC_EMB_NS);
    localparam int unsigned NEMB_CYC = pfb_pkg::pfb_cycles(P_REC_NEMB_NS);
    localparam int unsigned RH_CYC   = pfb_pkg::pfb_cycles(P_RH_NS);

    localparam pfb_pkg::pfb_cnt_t ACC_LD  = `PFB_TMR_W'(ACC_CYC - 1);
    localparam pfb_pkg::pfb_cnt_t WP_LD   = `PFB_TMR_W'(WP_CYC - 1);
    localparam pfb_pkg::pfb_cnt_t IP_LD   = `PFB_TMR_W'(IP_CYC - 1);
    localparam pfb_pkg::pfb_cnt_t EMB_LD  = `PFB_TMR_W'(EMB_CYC - 1);
    localparam pfb_pkg::pfb_cnt_t NEMB_LD = `PFB_TMR_W'(NEMB_CYC - 1);
    localparam pfb_pkg::pfb_cnt_t RH_LD   = `PFB_TMR_W'(RH_CYC - 1);

    pfb_tmr_if tmr ();

    pfb_timer i_pfb_timer (
        .MCLK (MCLK),
        .RST  (RST),
        .t    (tmr)
    );

    pfb_pkg::pfb_state_t    state_r,   state_nxt;
    logic                   ce_n_r,    ce_n_nxt;
    logic                   oe_n_r,    oe_n_nxt;
    logic                   we_n_r,    we_n_nxt;
    logic                   init_n_r,  init_n_nxt;
    logic                   dq_oe_r,   dq_oe_nxt;
    logic [`PFB_DATA_W-1:0] dq_o_r,    dq_o_nxt;
    logic [`PFB_ADDR_W-1:0] addr_r,    addr_nxt;
    logic [`PFB_DATA_W-1:0] rdata_r,   rdata_nxt;
    logic                   done_r,    done_nxt;
    logic                   abort_r,   abort_nxt;
    logic                   emb_r,     emb_nxt;

    // sequencer: next state and next pin levels
    always_comb begin
        state_nxt  = state_r;
        ce_n_nxt   = ce_n_r;
        oe_n_nxt   = oe_n_r;
        we_n_nxt   = we_n_r;
        init_n_nxt = init_n_r;
        dq_oe_nxt  = dq_oe_r;
        dq_o_nxt   = dq_o_r;
        addr_nxt   = addr_r;
        rdata_nxt  = rdata_r;
        done_nxt   = 1'b0;
        abort_nxt  = abort_r;
        emb_nxt    = emb_r;
        tmr.load   = 1'b0;
        tmr.value  = '0;
        unique case (state_r)
            pfb_pkg::PFB_PWRUP: begin
                // hold init low at power-up for array read mode
                init_n_nxt = 1'b0;
                emb_nxt    = 1'b0;
                tmr.load   = 1'b1;
                tmr.value  = IP_LD;
                state_nxt  = pfb_pkg::PFB_INIT_LOW;
            end
            pfb_pkg::PFB_IDLE: begin
                // idle keeps select and init high: standby
                if (REQ) begin
                    unique case (OP)
                        `PFB_OP_READ: begin
                            // full select access time on every read
                            ce_n_nxt  = 1'b0;
                            oe_n_nxt  = 1'b0;
                            addr_nxt  = ADDR_IN;
                            tmr.load  = 1'b1;
                            tmr.value = ACC_LD;
                            state_nxt = pfb_pkg::PFB_RD;
                        end
                        `PFB_OP_WRITE: begin
                            // command cycle: strobe and select low, gate high
                            ce_n_nxt  = 1'b0;
                            we_n_nxt  = 1'b0;
                            dq_oe_nxt = 1'b1;
                            dq_o_nxt  = WDATA;
                            addr_nxt  = ADDR_IN;
                            abort_nxt = 1'b0;
                            tmr.load  = 1'b1;
                            tmr.value = WP_LD;
                            state_nxt = pfb_pkg::PFB_WR;
                        end
                        `PFB_OP_INIT: begin
                            // busy flash: mark the aborted operation
                            init_n_nxt = 1'b0;
                            emb_nxt    = ~OP_DONE_FLAG;
                            abort_nxt  = abort_r | ~OP_DONE_FLAG;
                            tmr.load   = 1'b1;
                            tmr.value  = IP_LD;
                            state_nxt  = pfb_pkg::PFB_INIT_LOW;
                        end
                        default: begin
                            state_nxt = pfb_pkg::PFB_IDLE;
                        end
                    endcase
                end
            end
            pfb_pkg::PFB_RD: begin
                // sample array, code or status byte at end of access
                if (tmr.done) begin
                    rdata_nxt = DATA_BUS_I;
                    ce_n_nxt  = 1'b1;
                    oe_n_nxt  = 1'b1;
                    done_nxt  = 1'b1;
                    state_nxt = pfb_pkg::PFB_IDLE;
                end
            end
            pfb_pkg::PFB_WR: begin
                // rising strobe latches address and data in the flash
                if (tmr.done) begin
                    we_n_nxt  = 1'b1;
                    ce_n_nxt  = 1'b1;
                    state_nxt = pfb_pkg::PFB_WR_HOLD;
                end
            end
            pfb_pkg::PFB_WR_HOLD: begin
                // data held one cycle past the strobe, then released
                dq_oe_nxt = 1'b0;
                done_nxt  = 1'b1;
                state_nxt = pfb_pkg::PFB_IDLE;
            end
            pfb_pkg::PFB_INIT_LOW: begin
                // pins stay quiet while init is low
                if (tmr.done) begin
                    init_n_nxt = 1'b1;
                    tmr.load   = 1'b1;
                    tmr.value  = emb_r ? EMB_LD : NEMB_LD;
                    state_nxt  = pfb_pkg::PFB_INIT_REC;
                end
            end
            pfb_pkg::PFB_INIT_REC: begin
                if (tmr.done) begin
                    tmr.load  = 1'b1;
                    tmr.value = RH_LD;
                    state_nxt = pfb_pkg::PFB_INIT_RH;
                end
            end
            pfb_pkg::PFB_INIT_RH: begin
                // no read before release-to-read has passed
                if (tmr.done) begin
                    done_nxt  = 1'b1;
                    state_nxt = pfb_pkg::PFB_IDLE;
                end
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_r  <= pfb_pkg::PFB_PWRUP;
            ce_n_r   <= 1'b1;
            oe_n_r   <= 1'b1;
            we_n_r   <= 1'b1;
            init_n_r <= 1'b0;
            dq_oe_r  <= 1'b0;
            dq_o_r   <= 8'h00;
            addr_r   <= 21'h000000;
            rdata_r  <= 8'h00;
            done_r   <= 1'b0;
            abort_r  <= 1'b0;
            emb_r    <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            ce_n_r   <= ce_n_nxt;
            oe_n_r   <= oe_n_nxt;
            we_n_r   <= we_n_nxt;
            init_n_r <= init_n_nxt;
            dq_oe_r  <= dq_oe_nxt;
            dq_o_r   <= dq_o_nxt;
            addr_r   <= addr_nxt;
            rdata_r  <= rdata_nxt;
            done_r   <= done_nxt;
            abort_r  <= abort_nxt;
            emb_r    <= emb_nxt;
        end
    end

    // port drive
    assign READY_OUT   = (state_r == pfb_pkg::PFB_IDLE);
    assign DONE        = done_r;
    assign RDATA       = rdata_r;
    assign ABORTED     = abort_r;
    assign CE_N        = ce_n_r;
    assign OE_N        = oe_n_r;
    assign WE_N        = we_n_r;
    assign INIT_N      = init_n_r;
    assign ADDR_BUS    = addr_r;
    assign DATA_BUS_O  = dq_o_r;
    assign DATA_BUS_OE = dq_oe_r;

    // helper counters: init low width, read access, time since release
    pfb_pkg::pfb_cnt_t low_cnt_r, acc_cnt_r, rel_cnt_r;
    pfb_pkg::pfb_cnt_t low_cnt_nxt, acc_cnt_nxt, rel_cnt_nxt;

    always_comb begin
        low_cnt_nxt = INIT_N ? '0 : ((low_cnt_r == '1) ? low_cnt_r : low_cnt_r + 16'h0001);
        acc_cnt_nxt = (CE_N | OE_N) ? '0
                    : ((acc_cnt_r == '1) ? acc_cnt_r : acc_cnt_r + 16'h0001);
        rel_cnt_nxt = !INIT_N ? '0 : ((rel_cnt_r == '1) ? rel_cnt_r : rel_cnt_r + 16'h0001);
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            low_cnt_r <= '0;
            acc_cnt_r <= '0;
            rel_cnt_r <= '0;
        end else begin
            low_cnt_r <= low_cnt_nxt;
            acc_cnt_r <= acc_cnt_nxt;
            rel_cnt_r <= rel_cnt_nxt;
        end
    end

    rd_pins_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_r == pfb_pkg::PFB_RD) |-> (!CE_N && !OE_N && WE_N && !DATA_BUS_OE))
        else $error("read phase pin levels wrong");

    rd_data_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_r == pfb_pkg::PFB_RD && tmr.done) |=> (DONE && RDATA == $past(DATA_BUS_I)))
        else $error("read data not captured at end of access");

    wr_pins_a: assert property (@(posedge MCLK) disable iff (RST)
        !WE_N |-> (!CE_N && OE_N && DATA_BUS_OE))
        else $error("write strobe without select or with gate low");

    no_contend_a: assert property (@(posedge MCLK) disable iff (RST)
        DATA_BUS_OE |-> OE_N)
        else $error("host drives data while flash gate is low");

    init_quiet_a: assert property (@(posedge MCLK) disable iff (RST)
        !INIT_N |-> (CE_N && OE_N && WE_N && !DATA_BUS_OE))
        else $error("bus cycle attempted while init low");

    init_width_a: assert property (@(posedge MCLK) disable iff (RST)
        $rose(INIT_N) |-> (low_cnt_r >= `PFB_TMR_W'(IP_CYC)))
        else $error("init pulse shorter than minimum");

    acc_time_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_r == pfb_pkg::PFB_RD && tmr.done) |-> (acc_cnt_r == `PFB_TMR_W'(ACC_CYC - 1)))
        else $error("read sampled before select access time");

    rel_read_a: assert property (@(posedge MCLK) disable iff (RST)
        $fell(OE_N) |-> (rel_cnt_r >= `PFB_TMR_W'(RH_CYC)))
        else $error("read started too soon after init release");

    idle_stby_a: assert property (@(posedge MCLK) disable iff (RST)
        READY_OUT |-> (CE_N && INIT_N && OE_N && WE_N))
        else $error("idle without standby levels");

    abort_flag_a: assert property (@(posedge MCLK) disable iff (RST)
        (READY_OUT && REQ && OP == `PFB_OP_INIT && !OP_DONE_FLAG) |=> (ABORTED && !INIT_N))
        else $error("aborted operation not flagged");

    rec_pick_a: assert property (@(posedge MCLK) disable iff (RST)
        (state_r == pfb_pkg::PFB_INIT_LOW && tmr.done && emb_r) |=> (tmr.done == (EMB_LD == '0)))
        else $error("embedded recovery time not loaded");

endmodule

// >>> testbench/pfb_flash_model.sv
// Purpose: behavioural byte-wide flash answering the host controller
// Assumes: pins sampled on the falling MCLK edge, after the host has settled them
// Notes:   VIOL latches high on a short init pulse, a read too soon after release, or a read with strobe low or host driving
`timescale 1ns/1ps

module pfb_flash_model #(
    parameter int         ACC  = 9,
    parameter int         BUSY = 30,
    parameter int         REC  = 20,
    parameter int         IP   = 50,
    parameter int         RH   = 5,
    parameter logic [7:0] ID   = 8'h5C  // arbitrary identity value
) (
    input  wire logic        MCLK,
    input  wire logic        CE_N,
    input  wire logic        OE_N,
    input  wire logic        WE_N,
    input  wire logic        INIT_N,
    input  wire logic [20:0] ADDR_BUS,
    input  wire logic [7:0]  DATA_BUS_O,
    input  wire logic        DATA_BUS_OE,
    output logic [7:0]       DQ,
    output logic             RDY,
    output logic             VIOL
);
    logic [7:0]  mem [logic [20:0]];
    logic [31:0] ers  = '0;
    logic [20:0] pa   = '0;
    logic [7:0]  pd   = '0;
    logic [7:0]  last = '0;
    logic        we_q = 1'b1;
    logic        ce_q = 1'b1;
    logic        ab   = 1'b0;
    logic        er   = 1'b0;
    logic        drv;
    int          mode = 0;
    int          busy = 0;
    int          sel  = 0;
    int          lo   = 0;
    int          rel  = 1000;

    initial VIOL = 1'b0;

    // array contents, erased sectors read all ones
    function automatic logic [7:0] rd(input logic [20:0] a);
        if (mem.exists(a)) return mem[a];
        return ers[a[20:16]] ? 8'hFF : a[7:0] ^ 8'h5A;
    endfunction

    // output drive only while selected, gated and out of init
    assign drv = !CE_N && !OE_N && WE_N && INIT_N;
    assign DQ  = !(drv && sel >= ACC) ? ~last :
                 busy > 0 ? {~pd[7], 7'h00} :
                 mode == 1 ? ID : rd(ADDR_BUS);
    assign RDY = (busy == 0);

    // command latch, embedded timer and host timing checks
    always @(negedge MCLK) begin
        if (drv && sel >= ACC) last = DQ;
        if (!INIT_N) begin
            if (lo == 0 && busy > 0) begin
                busy = REC;
                ab = 1'b1;
            end
            lo++;
            mode = 0;
            sel = 0;
            rel = 0;
        end else begin
            if (lo > 0 && lo < IP) VIOL = 1'b1;
            lo = 0;
            rel++;
            if (!CE_N && !OE_N) begin
                sel++;
                if (rel < RH || !WE_N || DATA_BUS_OE) VIOL = 1'b1;
            end else begin
                sel = 0;
            end
            if (!we_q && !ce_q && WE_N && busy == 0) begin
                if (mode == 2) begin
                    pa = ADDR_BUS;
                    pd = DATA_BUS_O;
                    busy = BUSY;
                    mode = 0;
                end else if (DATA_BUS_O == 8'h90) mode = 1;
                else if (DATA_BUS_O == 8'hF0) mode = 0;
                else if (DATA_BUS_O == 8'hA0) mode = 2;
                else if (DATA_BUS_O == 8'h30) begin
                    pa = ADDR_BUS;
                    pd = 8'hFF;
                    busy = BUSY;
                    er = 1'b1;
                end
            end
        end
        if (busy > 0) begin
            busy--;
            if (busy == 0 && !ab && er) ers[pa[20:16]] = 1'b1;
            else if (busy == 0 && !ab) mem[pa] = pd;
            if (busy == 0) ab = 1'b0;
            if (busy == 0) er = 1'b0;
        end
        we_q = WE_N;
        ce_q = CE_N;
    end
endmodule

// >>> testbench/pfb_host_tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model on the pins, short embedded recovery for speed
// Notes:   latencies follow the controller's cycle figures
`timescale 1ns/1ps
`include "pfb_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module pfb_host_tb;
    logic                   MCLK    = 1'b0;
    logic                   RST     = 1'b1;
    logic                   REQ     = 1'b0;
    logic [1:0]             OP      = 2'h0;
    logic [`PFB_ADDR_W-1:0] ADDR_IN = '0;
    logic [`PFB_DATA_W-1:0] WDATA   = '0;
    logic [`PFB_DATA_W-1:0] RDATA, DATA_BUS_O, DATA_BUS_I, fdq;
    logic [`PFB_ADDR_W-1:0] ADDR_BUS;
    logic                   READY_OUT, DONE, ABORTED, CE_N, OE_N, WE_N, INIT_N;
    logic                   DATA_BUS_OE, OP_DONE_FLAG, VIOL;
    int                     n_fail   = 0;
    int                     n_checks = 0;
    int                     n        = 0;

    pfb_host #(.P_REC_EMB_NS(200)) i_pfb_host (.MCLK(MCLK), .RST(RST), .REQ(REQ), .OP(OP),
        .ADDR_IN(ADDR_IN), .WDATA(WDATA), .READY_OUT(READY_OUT), .DONE(DONE), .RDATA(RDATA),
        .ABORTED(ABORTED), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .INIT_N(INIT_N),
        .ADDR_BUS(ADDR_BUS), .DATA_BUS_I(DATA_BUS_I), .DATA_BUS_O(DATA_BUS_O),
        .DATA_BUS_OE(DATA_BUS_OE), .OP_DONE_FLAG(OP_DONE_FLAG));

    pfb_flash_model i_pfb_flash_model (.MCLK(MCLK), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
        .INIT_N(INIT_N), .ADDR_BUS(ADDR_BUS), .DATA_BUS_O(DATA_BUS_O),
        .DATA_BUS_OE(DATA_BUS_OE), .DQ(fdq), .RDY(OP_DONE_FLAG), .VIOL(VIOL));

    // shared data wire, host drive wins while enabled
    assign DATA_BUS_I = DATA_BUS_OE ? DATA_BUS_O : fdq;

    // clock
    initial begin
        forever #5 MCLK = ~MCLK;
    end

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic timeout;
        n_fail++;
        summarize;
    endtask

    task automatic wait_rdy;
        int k = 0;
        while (READY_OUT !== 1'b1 && k < 500) begin
            @(posedge MCLK);
            #1 k = k + 1;
        end
        if (k >= 500) timeout;
    endtask

    task automatic wait_flag;
        int k = 0;
        while (OP_DONE_FLAG !== 1'b1 && k < 200) begin
            @(posedge MCLK);
            #1 k = k + 1;
        end
        if (k >= 200) timeout;
    endtask

    // cycles from the taking edge to the done pulse
    task automatic wait_done;
        n = 0;
        while (DONE !== 1'b1 && n < 200) begin
            @(posedge MCLK);
            #1 n = n + 1;
        end
        if (n >= 200) timeout;
    endtask

    task automatic op(input logic [1:0] o, input logic [20:0] a, input logic [7:0] d);
        wait_rdy;
        OP = o;
        ADDR_IN = a;
        WDATA = d;
        REQ = 1'b1;
        @(posedge MCLK);
        #1 REQ = 1'b0;
        wait_done;
    endtask

    task automatic rd(input logic [20:0] a, input logic [7:0] e);
        op(2'h0, a, 8'h00);
        `CHK(n, 9)
        `CHK(RDATA, e)
    endtask

    task automatic t_prog;
        op(2'h1, 21'h000040, 8'hA0);
        `CHK(n, 6)
        op(2'h1, 21'h000040, 8'h3C);
        `CHK(OP_DONE_FLAG, 1'b0)
        rd(21'h000040, 8'h80);
        wait_flag;
        rd(21'h000040, 8'h3C);
    endtask

    task automatic t_modes;
        op(2'h1, 21'h050000, 8'h30);
        wait_flag;
        rd(21'h050011, 8'hFF);
        rd(21'h060011, 8'h4B);
        op(2'h1, 21'h000000, 8'h90);
        rd(21'h000007, 8'h5C);
        op(2'h1, 21'h000000, 8'hF0);
        rd(21'h000007, 8'h5D);
    endtask

    // requests while busy and unknown codes must be dropped
    task automatic t_refuse;
        wait_rdy;
        OP = 2'h0;
        ADDR_IN = 21'h000123;
        REQ = 1'b1;
        @(posedge MCLK);
        #1 OP = 2'h1;
        WDATA = 8'h90;
        wait_done;
        `CHK(RDATA, 8'h79)
        OP = 2'h3;
        repeat (3) begin
            @(posedge MCLK);
            #1 `CHK({DONE, READY_OUT}, 2'b01)
        end
        REQ = 1'b0;
        rd(21'h000123, 8'h79);
    endtask

    task automatic t_init;
        op(2'h1, 21'h000200, 8'hA0);
        op(2'h1, 21'h000200, 8'h55);
        op(2'h2, 21'h000000, 8'h00);
        `CHK(n, 75)
        `CHK(ABORTED, 1'b1)
        `CHK(OP_DONE_FLAG, 1'b1)
        rd(21'h000200, 8'h5A);
        op(2'h1, 21'h000200, 8'hA0);
        `CHK(ABORTED, 1'b0)
        op(2'h1, 21'h000200, 8'h55);
        wait_flag;
        rd(21'h000200, 8'h55);
        op(2'h2, 21'h000000, 8'h00);
        `CHK(n, 105)
        `CHK(ABORTED, 1'b0)
    endtask

    // pin levels watched every cycle
    always @(negedge MCLK) begin
        if (!RST && !INIT_N) `CHK({CE_N, OE_N, WE_N}, 3'h7)
        if (!RST && READY_OUT) `CHK(CE_N, 1'b1)
        if (!RST && !OE_N) `CHK(DATA_BUS_OE, 1'b0)
    end

    // main sequence
    initial begin
        repeat (16) @(posedge MCLK);
        `CHK(INIT_N, 1'b0)
        #1 RST = 1'b0;
        wait_rdy;
        `CHK(ABORTED, 1'b0)
        rd(21'h000123, 8'h79);
        t_prog;
        t_modes;
        t_refuse;
        t_init;
        `CHK(VIOL, 1'b0)
        summarize;
    end
endmodule
